// ==== lpd_consts.svh ====
`ifndef LPD_CONSTS_SVH
`define LPD_CONSTS_SVH
`define LPD_ADDR_W           6
`define LPD_DATA_W           13
`define LPD_ADDR_PSEL10      6'h2a
`define LPD_ADDR_PSEL11      6'h2b
`define LPD_ADDR_PSEL12      6'h2c
`define LPD_ADDR_GRP         6'h30
`define LPD_ADDR_PER123      6'h31
`define LPD_RST_PSEL10       8'hc0
`define LPD_RST_PSEL11       8'hd5
`define LPD_RST_PSEL12       8'hea
`define LPD_RST_GROUP        2'h1
`define LPD_RST_PERIOD       3'h0
`define LPD_GRP_CODE_LSB     0
`define LPD_GRP_SEL_LSB      4
`define LPD_LED1_LSB         0
`define LPD_LED2_LSB         4
`define LPD_LED3_LSB         8
`define LPD_PWM_PERIOD_CLKS  14'h2000
`define LPD_MAX_PERIODS      6'h20
`define LPD_MAX_SPAN_CLKS    19'h40000
`endif

// ==== lpd_pkg.sv ====
`default_nettype none
package lpd_pkg;
  typedef struct packed {
    logic       wr;
    logic [5:0] addr;
    logic [12:0] wdata;
  } lpd_req_t;
  typedef struct packed {
    logic [7:0]  phase10;
    logic [7:0]  phase11;
    logic [7:0]  phase12;
    logic [1:0]  group_sel;
    logic [2:0]  bcast_code;
    logic [2:0]  led1_period;
    logic [2:0]  led2_period;
    logic [2:0]  led3_period;
    logic [12:0] rdata;
    logic [2:0]  upd;
    logic [17:0] cnt1;
    logic [17:0] cnt2;
    logic [17:0] cnt3;
    logic [18:0] gap1;
    logic        moved1;
  } lpd_state_t;
endpackage
`default_nettype wire

// ==== lpd_regs.sv ====
// Behaviour
// [R1] LED10..12 phase selects: 8-bit RW at 0x2A, 0x2B, 0x2C.
// [R2] Group write copies period code bits 2:0 into each member LED's field.
// [R3] Bit 4 selects group A, bit 5 group B; both allowed.
// [R4] Group write with no group selected: no broadcast, stored select unchanged.
// [R5] Period code 0..4 gives 1,2,4,8,16 PWM periods; 5..7 give 32.
// [R6] Duty applied once per dimming period; PWM period 8192 clocks.
// [R7] LED3/2/1 period fields at 10:8, 6:4, 2:0 of 0x31, reset zero.
// [R8] Membership from group-A/B membership inputs; members read back broadcast.
// [R9] Unused bits read zero, writes to them ignored.
`timescale 1ns/10ps
`include "lpd_consts.svh"
`default_nettype none
module lpd_regs
  import lpd_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire lpd_req_t    REQ,
  input  wire logic [2:0]  GROUP_A_MEMBERSHIP,
  input  wire logic [2:0]  GROUP_B_MEMBERSHIP,
  output logic      [12:0] RDATA,
  output logic      [7:0]  LED10_PHASE,
  output logic      [7:0]  LED11_PHASE,
  output logic      [7:0]  LED12_PHASE,
  output logic      [8:0]  LED_PERIOD_CODES,
  output logic      [2:0]  DUTY_UPDATE
);
  lpd_state_t st_reg;
  lpd_state_t st_next;
  logic [2:0] members;
  logic [2:0]  code [3];
  logic [17:0] span_last [3];
  logic [17:0] cnt_now [3];
  logic [17:0] cnt_new [3];

  // Last count of a span; 32 periods is 2^18 clocks, so keep span minus one
  function automatic logic [17:0] periods_to_last(input logic [2:0] c);
    logic [5:0]  n;
    logic [18:0] clks;
    n               = (c >= 3'h5) ? `LPD_MAX_PERIODS : 6'(6'h1 << c); // R5
    clks            = 19'(n) * 19'(`LPD_PWM_PERIOD_CLKS); // R6
    periods_to_last = 18'(clks - 19'h1);
  endfunction

  assign code[0]    = st_reg.led1_period;
  assign code[1]    = st_reg.led2_period;
  assign code[2]    = st_reg.led3_period;
  assign cnt_now[0] = st_reg.cnt1;
  assign cnt_now[1] = st_reg.cnt2;
  assign cnt_now[2] = st_reg.cnt3;

  // One free-running counter per LED; a shrunk span wraps at once
  for (genvar g = 0; g < 3; g++) begin : g_led
    assign span_last[g] = periods_to_last(code[g]);
    assign cnt_new[g]   = (cnt_now[g] >= span_last[g]) ? 18'h0 : cnt_now[g] + 18'h1; // R6
  end

  // Members of every selected group; sel 00 yields nothing to write
  assign members = ({3{REQ.wdata[`LPD_GRP_SEL_LSB]}} & GROUP_A_MEMBERSHIP)      // R3 R8
                 | ({3{REQ.wdata[`LPD_GRP_SEL_LSB+1]}} & GROUP_B_MEMBERSHIP);   // R3

  always_comb begin
    logic [2:0] bc;
    bc = REQ.wdata[`LPD_GRP_CODE_LSB +: 3];
    st_next = st_reg;
    if (REQ.wr) begin
      case (REQ.addr)
        `LPD_ADDR_PSEL10: st_next.phase10 = REQ.wdata[7:0]; // R1 R9
        `LPD_ADDR_PSEL11: st_next.phase11 = REQ.wdata[7:0]; // R1
        `LPD_ADDR_PSEL12: st_next.phase12 = REQ.wdata[7:0]; // R1
        `LPD_ADDR_GRP: begin
          if (REQ.wdata[`LPD_GRP_SEL_LSB +: 2] != 2'h0) begin // R4
            st_next.group_sel  = REQ.wdata[`LPD_GRP_SEL_LSB +: 2];
            st_next.bcast_code = bc;
            if (members[0]) st_next.led1_period = bc; // R2
            if (members[1]) st_next.led2_period = bc; // R2
            if (members[2]) st_next.led3_period = bc; // R2
          end
        end
        `LPD_ADDR_PER123: begin
          st_next.led1_period = REQ.wdata[`LPD_LED1_LSB +: 3]; // R7
          st_next.led2_period = REQ.wdata[`LPD_LED2_LSB +: 3]; // R7
          st_next.led3_period = REQ.wdata[`LPD_LED3_LSB +: 3]; // R7
        end
        default: ;
      endcase
    end
    case (REQ.addr)
      `LPD_ADDR_PSEL10: st_next.rdata = {5'h0, st_reg.phase10}; // R9
      `LPD_ADDR_PSEL11: st_next.rdata = {5'h0, st_reg.phase11};
      `LPD_ADDR_PSEL12: st_next.rdata = {5'h0, st_reg.phase12};
      `LPD_ADDR_GRP:    st_next.rdata = {7'h0, st_reg.group_sel, 1'b0, st_reg.bcast_code};
      `LPD_ADDR_PER123: st_next.rdata = {2'h0, st_reg.led3_period, 1'b0,
                                         st_reg.led2_period, 1'b0, st_reg.led1_period};
      default:          st_next.rdata = 13'h0;
    endcase
    // Per-LED update counters; a new duty is taken only at span end
    st_next.upd    = 3'h0;
    st_next.cnt1   = cnt_new[0]; // R6
    st_next.cnt2   = cnt_new[1];
    st_next.cnt3   = cnt_new[2];
    st_next.upd[0] = (cnt_new[0] == 18'h0); // R6
    st_next.upd[1] = (cnt_new[1] == 18'h0);
    st_next.upd[2] = (cnt_new[2] == 18'h0);
    // Checker aid: clocks since last LED1 update, and a code-change mark
    st_next.gap1   = st_reg.upd[0] ? 19'h1
                   : ((&st_reg.gap1) ? st_reg.gap1 : st_reg.gap1 + 19'h1);
    st_next.moved1 = (st_next.led1_period != st_reg.led1_period)
                   | (st_reg.moved1 & ~st_reg.upd[0]);
    if (RST) begin
      st_next = '0;
      st_next.phase10   = `LPD_RST_PSEL10;
      st_next.phase11   = `LPD_RST_PSEL11;
      st_next.phase12   = `LPD_RST_PSEL12;
      st_next.group_sel = `LPD_RST_GROUP;
    end
  end

  always_ff @(posedge CLK) begin
    st_reg <= st_next;
  end

  assign RDATA            = st_reg.rdata;
  assign LED10_PHASE      = st_reg.phase10;
  assign LED11_PHASE      = st_reg.phase11;
  assign LED12_PHASE      = st_reg.phase12;
  assign LED_PERIOD_CODES = {st_reg.led3_period, st_reg.led2_period, st_reg.led1_period};
  assign DUTY_UPDATE      = st_reg.upd;

  property p_phase_write;
    @(posedge CLK) disable iff (RST)
      REQ.wr && REQ.addr == `LPD_ADDR_PSEL11 |=> LED11_PHASE == $past(REQ.wdata[7:0]);
  endproperty
  a_phase_write: assert property (p_phase_write) else $error("phase write lost"); // R1

  property p_phase10_write;
    @(posedge CLK) disable iff (RST)
      REQ.wr && REQ.addr == `LPD_ADDR_PSEL10 |=> LED10_PHASE == $past(REQ.wdata[7:0]);
  endproperty
  a_phase10_write: assert property (p_phase10_write) else $error("phase 10 write lost"); // R1 R9

  property p_phase12_write;
    @(posedge CLK) disable iff (RST)
      REQ.wr && REQ.addr == `LPD_ADDR_PSEL12 |=> LED12_PHASE == $past(REQ.wdata[7:0]);
  endproperty
  a_phase12_write: assert property (p_phase12_write) else $error("phase 12 write lost"); // R1

  property p_bcast;
    @(posedge CLK) disable iff (RST)
      REQ.wr && REQ.addr == `LPD_ADDR_GRP && REQ.wdata[4] && GROUP_A_MEMBERSHIP[2]
      |=> LED_PERIOD_CODES[8:6] == $past(REQ.wdata[2:0]);
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast not applied"); // R2

  property p_grp_b;
    @(posedge CLK) disable iff (RST)
      REQ.wr && REQ.addr == `LPD_ADDR_GRP && REQ.wdata[5:4] == 2'h2 && GROUP_B_MEMBERSHIP[1]
      |=> LED_PERIOD_CODES[5:3] == $past(REQ.wdata[2:0]);
  endproperty
  a_grp_b: assert property (p_grp_b) else $error("group B not applied"); // R3

  property p_no_group;
    @(posedge CLK) disable iff (RST)
      REQ.wr && REQ.addr == `LPD_ADDR_GRP && REQ.wdata[5:4] == 2'h0
      |=> $stable(LED_PERIOD_CODES) && $stable(st_reg.group_sel);
  endproperty
  a_no_group: assert property (p_no_group) else $error("empty group write acted"); // R4

  property p_group_sel_store;
    @(posedge CLK) disable iff (RST)
      REQ.wr && REQ.addr == `LPD_ADDR_GRP && REQ.wdata[5:4] != 2'h0
      |=> st_reg.group_sel == $past(REQ.wdata[5:4]);
  endproperty
  a_group_sel_store: assert property (p_group_sel_store) else $error("group select lost"); // R3 R4

  property p_span_max;
    @(posedge CLK) disable iff (RST)
      st_reg.led1_period >= 3'h5 |-> span_last[0] == 18'(`LPD_MAX_SPAN_CLKS - 19'h1);
  endproperty
  a_span_max: assert property (p_span_max) else $error("period decode wrong"); // R5

  property p_span_min;
    @(posedge CLK) disable iff (RST)
      st_reg.led1_period == 3'h0 |-> span_last[0] == 18'(`LPD_PWM_PERIOD_CLKS - 14'h1);
  endproperty
  a_span_min: assert property (p_span_min) else $error("single period decode wrong"); // R5

  property p_span_16;
    @(posedge CLK) disable iff (RST)
      st_reg.led2_period == 3'h4
      |-> span_last[1] == 18'(19'(`LPD_PWM_PERIOD_CLKS) * 19'h10 - 19'h1);
  endproperty
  a_span_16: assert property (p_span_16) else $error("16 period decode wrong"); // R5

  // Spacing checked on a helper count; a long delay would stall the tools
  property p_update_spacing;
    @(posedge CLK) disable iff (RST)
      DUTY_UPDATE[0] && !st_reg.moved1 && st_reg.led1_period == 3'h0
      |-> st_reg.gap1 == 19'(`LPD_PWM_PERIOD_CLKS);
  endproperty
  a_update_spacing: assert property (p_update_spacing) else $error("update spacing wrong"); // R6

  property p_update_max;
    @(posedge CLK) disable iff (RST)
      DUTY_UPDATE[0] |-> st_reg.gap1 <= `LPD_MAX_SPAN_CLKS;
  endproperty
  a_update_max: assert property (p_update_max) else $error("update gap too long"); // R6

  property p_update_pulse;
    @(posedge CLK) disable iff (RST)
      DUTY_UPDATE[0] |=> !DUTY_UPDATE[0];
  endproperty
  a_update_pulse: assert property (p_update_pulse) else $error("update pulse too long"); // R6

  property p_direct;
    @(posedge CLK) disable iff (RST)
      REQ.wr && REQ.addr == `LPD_ADDR_PER123
      |=> LED_PERIOD_CODES == {$past(REQ.wdata[10:8]), $past(REQ.wdata[6:4]), $past(REQ.wdata[2:0])};
  endproperty
  a_direct: assert property (p_direct) else $error("period field write lost"); // R7

  property p_readback;
    @(posedge CLK) disable iff (RST)
      REQ.addr == `LPD_ADDR_PER123 |=> RDATA == {2'h0, $past(LED_PERIOD_CODES[8:6]), 1'b0,
        $past(LED_PERIOD_CODES[5:3]), 1'b0, $past(LED_PERIOD_CODES[2:0])};
  endproperty
  a_readback: assert property (p_readback) else $error("readback wrong"); // R8 R9

  property p_rdata_unmapped;
    @(posedge CLK) disable iff (RST)
      !(REQ.addr inside {`LPD_ADDR_PSEL10, `LPD_ADDR_PSEL11, `LPD_ADDR_PSEL12,
                         `LPD_ADDR_GRP, `LPD_ADDR_PER123})
      |=> RDATA == 13'h0;
  endproperty
  a_rdata_unmapped: assert property (p_rdata_unmapped) else $error("unmapped read not zero"); // R9
endmodule
`default_nettype wire

// ==== test_lpd_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
`define TB_CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module test_lpd_regs
  import lpd_pkg::*;
;
  logic        CLK;
  logic        RST;
  lpd_req_t    req;
  logic [2:0]  grp_a;
  logic [2:0]  grp_b;
  logic [12:0] rdata;
  logic [7:0]  ph10;
  logic [7:0]  ph11;
  logic [7:0]  ph12;
  logic [8:0]  codes;
  logic [2:0]  upd;
  int          fail_count;
  int          samples_checked;
  int          cyc;
  lpd_regs uut (.CLK(CLK), .RST(RST), .REQ(req), .GROUP_A_MEMBERSHIP(grp_a),
    .GROUP_B_MEMBERSHIP(grp_b), .RDATA(rdata), .LED10_PHASE(ph10), .LED11_PHASE(ph11),
    .LED12_PHASE(ph12), .LED_PERIOD_CODES(codes), .DUTY_UPDATE(upd));
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Hang guard sized for the whole run, which ends with the longest period measurement
  always @(posedge CLK) begin
    cyc++;
    if (cyc > 96000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic wr(input logic [5:0] a, input logic [12:0] d);
    @(posedge CLK);
    req <= '{1'b1, a, d};
    @(posedge CLK);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [12:0] ex);
    @(posedge CLK);
    req <= '{1'b0, a, 13'h0000};
    @(posedge CLK);
    @(negedge CLK);
    `TB_CHK("rdata", ex, rdata)
  endtask
  task automatic t_reset;
    logic [5:0]  a [6] = '{6'h2a, 6'h2b, 6'h2c, 6'h30, 6'h31, 6'h3f};
    logic [12:0] e [6] = '{13'h00c0, 13'h00d5, 13'h00ea, 13'h0010, 13'h0000, 13'h0000};
    for (int i = 0; i < 6; i++) rd(a[i], e[i]);
  endtask
  task automatic t_phase;
    wr(6'h2a, 13'h1fff);
    wr(6'h2b, 13'h0012);
    wr(6'h2c, 13'h0000);
    @(negedge CLK);
    `TB_CHK("led10_phase", 8'hff, ph10)
    `TB_CHK("led11_phase", 8'h12, ph11)
    `TB_CHK("led12_phase", 8'h00, ph12)
    rd(6'h2a, 13'h00ff);
    wr(6'h31, 13'h1fff);
    rd(6'h31, 13'h0777);
  endtask
  // Group A holds LED1 and LED3, group B holds LED2
  task automatic t_group;
    wr(6'h30, 13'h1f13);
    @(negedge CLK);
    `TB_CHK("codes", 9'h0fb, codes)
    wr(6'h30, 13'h0025);
    @(negedge CLK);
    `TB_CHK("codes", 9'h0eb, codes)
    wr(6'h30, 13'h0032);
    @(negedge CLK);
    `TB_CHK("codes", 9'h092, codes)
    wr(6'h30, 13'h0006);
    @(negedge CLK);
    `TB_CHK("codes", 9'h092, codes)
    rd(6'h30, 13'h0032);
  endtask
  // Mid-run reset lines all three update counters up
  task automatic t_rerun;
    int n;
    @(posedge CLK);
    RST <= 1'b1;
    @(posedge CLK);
    RST <= 1'b0;
    @(negedge CLK);
    `TB_CHK("codes", 9'h000, codes)
    `TB_CHK("led10_phase", 8'hc0, ph10)
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while (upd === 3'h0 && n < 9000);
    `TB_CHK("update_all", 3'h7, upd)
    `TB_CHK("first_update", 8192, n)
  endtask
  task automatic wait_upd;
    @(negedge CLK);
    while (upd[0] !== 1'b1) @(negedge CLK);
  endtask
  // First gap after a code change may still use the old span, so skip it
  task automatic span(input logic [12:0] code, input logic [31:0] ex);
    logic [31:0] n;
    wr(6'h31, code);
    wait_upd();
    wait_upd();
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while (upd[0] !== 1'b1);
    `TB_CHK("update_gap", ex, n)
  endtask
  initial begin
    RST = 1'b1;
    req = '0;
    grp_a = 3'b101;
    grp_b = 3'b010;
    cyc = 0;
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    t_reset();
    t_phase();
    t_group();
    t_rerun();
    span(13'h0000, 32'd8192);
    span(13'h0001, 32'd16384);
    tally_and_finish();
  end
endmodule
`default_nettype wire
